//--- inc/cds_params.svh
`ifndef CDS_PARAMS_SVH
`define CDS_PARAMS_SVH

// ****************************************************************
// instruction fields (first word; the CDS_CNT_B_MSB field and the chroma counts are in the second word)
// ****************************************************************
`define CDS_OP_MSB 31
`define CDS_OP_LSB 28
`define CDS_LINE_FIRST_BIT 27
`define CDS_LINE_LAST_BIT 26
`define CDS_IRQ_BIT 24
`define CDS_FLAG_CLR_MSB 23
`define CDS_FLAG_CLR_LSB 20
`define CDS_FLAG_SET_MSB 19
`define CDS_FLAG_SET_LSB 16
`define CDS_OVERRIDE_BIT 15
`define CDS_CNT_A_MSB 11
`define CDS_CNT_A_LSB 0
`define CDS_CNT_B_MSB 27
`define CDS_CNT_B_LSB 16
`define CDS_SYNC_CODE_MSB 3
`define CDS_SYNC_CODE_LSB 0

// ****************************************************************
// opcodes and sync codes
// ****************************************************************
`define CDS_OP_PACKED_DISCARD 4'h2
`define CDS_OP_PLANAR_DISCARD 4'hA
`define CDS_OP_BRANCH 4'h7
`define CDS_OP_SYNC 4'h8
`define CDS_SYNC_VALID_CODES 16'hFFFE

// ****************************************************************
// register map (byte addresses) and reset values
// ****************************************************************
`define CDS_REG_CTRL 8'h00
`define CDS_REG_START_PC 8'h04
`define CDS_REG_PC 8'h08
`define CDS_REG_FLAGS 8'h0C
`define CDS_REG_INT_STAT 8'h10
`define CDS_REG_INT_MASK 8'h14
`define CDS_RST_INT_MASK 4'h0
`define CDS_RST_FLAGS 4'h0
`define CDS_HALT_BIT 8

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define CDS_INT_INSTR 0
`define CDS_INT_ERROR 1
`define CDS_INT_SYNC_ERR 2
`define CDS_INT_LINE_ABORT 3

`endif

//--- inc/cds_pkg.sv
package cds_pkg;

   // ****************************************************************
   // sequencer states, one-hot
   // ****************************************************************
   typedef enum logic [6:0] {
      cds_st_idle = 7'h01,
      cds_st_fetch = 7'h02,
      cds_st_decode = 7'h04,
      cds_st_exec = 7'h08,
      cds_st_sync = 7'h10,
      cds_st_done = 7'h20,
      cds_st_halt = 7'h40
   } cds_state_t;

   // ****************************************************************
   // sequencer state
   // ****************************************************************
   typedef struct packed {
      cds_state_t st;
      logic en;
      logic [31:0] start_pc;
      logic [31:0] pc;
      logic [31:0] dw0;
      logic [31:0] dw1;
      logic widx;
      logic skip_line;
      logic kill;
      logic [2:0] done_mask;
      logic [3:0] flags;
      logic [3:0] int_stat;
      logic [3:0] int_mask;
      logic [31:0] prdata;
   } cds_seq_t;

   // ****************************************************************
   // byte discard engine state
   // ****************************************************************
   typedef struct packed {
      logic busy;
      logic word_mode;
      logic [11:0] rem;
      logic [1:0] ofs;
   } cds_eng_t;

endpackage

//--- inc/cds_discard_if.sv
`timescale 1ns/100ps
`default_nettype none

// sequencer to byte discard engine, one per fifo lane
interface cds_discard_if;
   logic start; // start a discard run, one cycle
   logic word_mode; // pop whole words until aborted (sync)
   logic abort; // stop the run now
   logic [11:0] count; // bytes to drop
   logic done; // run finishes this cycle
   logic eol_hit; // popped word carried end of line
   logic fifo_valid; // fifo head word present
   logic fifo_eol; // head word ends the line
   logic fifo_pop; // head word consumed

   modport ctrl (output start, word_mode, abort, count, fifo_valid, fifo_eol,
                 input done, eol_hit, fifo_pop);
   modport eng (input start, word_mode, abort, count, fifo_valid, fifo_eol,
                output done, eol_hit, fifo_pop);
endinterface // cds_discard_if

`default_nettype wire

//--- rtl/cds_byte_discard.sv
`timescale 1ns/100ps
`default_nettype none

`include "cds_params.svh"

module cds_byte_discard (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // sequencer side
   cds_discard_if.eng bus
);

   cds_pkg::cds_eng_t r; // registered state
   cds_pkg::cds_eng_t n; // next state
   logic [2:0] avail; // bytes left in head word
   logic [2:0] take; // bytes dropped this cycle
   logic go; // run advances this cycle

   // ****************************************************************
   // byte bookkeeping
   // ****************************************************************
   assign avail = 3'h4 - {1'b0, r.ofs};
   assign take = (r.rem < {9'h000, avail}) ? r.rem[2:0] : avail;
   assign go = r.busy & bus.fifo_valid & ~bus.abort;
   // a word leaves the fifo only when its last byte is dropped
   assign bus.fifo_pop = go & (r.word_mode | (take == avail));
   assign bus.eol_hit = bus.fifo_pop & bus.fifo_eol;
   assign bus.done = (bus.start & ~bus.word_mode & (bus.count == 12'h000)) |
                     (go & ~r.word_mode & (r.rem <= {9'h000, avail}));

   // next state
   always_comb begin
      n = r;
      if (bus.abort) begin
         n.busy = 1'b0;
         // a sync match leaves the stream aligned on a word
         if (r.word_mode) begin
            n.ofs = 2'h0;
         end
      end else if (go & ~r.word_mode) begin
         // partial words keep their offset for the next run
         n.rem = r.rem - {9'h000, take};
         n.ofs = r.ofs + take[1:0];
         if (r.rem <= {9'h000, avail}) begin
            n.busy = 1'b0;
         end
      end
      if (bus.start) begin
         n.busy = bus.word_mode | (bus.count != 12'h000);
         n.word_mode = bus.word_mode;
         n.rem = bus.count;
      end
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

endmodule // cds_byte_discard

`default_nettype wire

//--- rtl/cds_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

`include "cds_params.svh"

module cds_sequencer (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // apb register port
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // instruction fetch
   output logic fetch_req_o,
   output logic [31:0] fetch_addr_o,
   input wire logic fetch_valid_i,
   input wire logic [31:0] fetch_data_i,
   // pixel fifos
   input wire logic [2:0] fifo_valid_i,
   input wire logic [2:0] fifo_eol_i,
   input wire logic [3:0] fifo_status_i,
   output logic [2:0] fifo_pop_o,
   // status
   output logic [3:0] program_status_flags_o,
   output logic irq_o
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************

   // opcode handled by this sequencer
   function automatic logic op_valid(input logic [3:0] op);
      op_valid = (op == `CDS_OP_PACKED_DISCARD) || (op == `CDS_OP_PLANAR_DISCARD) ||
                 (op == `CDS_OP_BRANCH) || (op == `CDS_OP_SYNC);
   endfunction

   // opcode with a second word
   function automatic logic op_two_words(input logic [3:0] op);
      op_two_words = (op == `CDS_OP_PLANAR_DISCARD) || (op == `CDS_OP_BRANCH) ||
                     (op == `CDS_OP_SYNC);
   endfunction

   // register address in the map
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `CDS_REG_CTRL) || (a == `CDS_REG_START_PC) || (a == `CDS_REG_PC) ||
                (a == `CDS_REG_FLAGS) || (a == `CDS_REG_INT_STAT) ||
                (a == `CDS_REG_INT_MASK);
   endfunction

   // ****************************************************************
   // declarations
   // ****************************************************************
   cds_pkg::cds_seq_t r; // registered state
   cds_pkg::cds_seq_t n; // next state
   logic [3:0] op; // opcode of the held instruction
   logic [15:0] sync_codes; // legal sync status codes
   logic bad_instr; // opcode or sync code not usable
   logic is_discard; // packed or planar discard
   logic skip_it; // discard dropped by a line abort
   logic dispatch; // start execution this cycle
   logic match; // sync status found at fifo head
   logic eol_early; // line ended before the count
   logic [2:0] eng_start; // engine start per lane
   logic [2:0] eng_word; // engine word mode per lane
   logic [2:0] eng_abort; // engine abort per lane
   logic [11:0] eng_count [3]; // engine counts per lane
   logic [2:0] eng_done; // engine finished per lane
   logic [2:0] eng_eol; // engine popped end of line
   logic apb_wr; // write access phase
   logic apb_setup; // setup phase
   logic [3:0] ev; // interrupt events this cycle
   logic [3:0] clr; // write one to clear mask

   cds_discard_if dif[3] ();

   // ****************************************************************
   // instruction decode
   // ****************************************************************
   assign op = r.dw0[`CDS_OP_MSB:`CDS_OP_LSB];
   assign sync_codes = `CDS_SYNC_VALID_CODES;
   assign is_discard = (op == `CDS_OP_PACKED_DISCARD) || (op == `CDS_OP_PLANAR_DISCARD);
   // unknown opcodes and unused sync codes are fatal
   assign bad_instr = !op_valid(op) || ((op == `CDS_OP_SYNC) &&
                      !sync_codes[r.dw0[`CDS_SYNC_CODE_MSB:`CDS_SYNC_CODE_LSB]]);
   // while a line is aborted, discards are dropped unless one opens a line
   assign skip_it = is_discard & r.skip_line & ~r.dw0[`CDS_LINE_FIRST_BIT];
   assign dispatch = (r.st == cds_pkg::cds_st_decode) & ~bad_instr & ~skip_it;

   // lanes started by the held instruction
   always_comb begin
      eng_start = 3'h0;
      if (dispatch) begin
         case (op)
            `CDS_OP_PACKED_DISCARD: eng_start = 3'h1;
            `CDS_OP_PLANAR_DISCARD: eng_start = 3'h7;
            `CDS_OP_SYNC: eng_start = 3'h1;
            default: eng_start = 3'h0;
         endcase
      end
   end

   // sync runs the luma lane in whole word mode
   assign eng_word = {2'b00, op == `CDS_OP_SYNC};
   // counts: luma from the first word, chroma from the second
   assign eng_count[0] = r.dw0[`CDS_CNT_A_MSB:`CDS_CNT_A_LSB];
   assign eng_count[1] = r.dw1[`CDS_CNT_A_MSB:`CDS_CNT_A_LSB];
   assign eng_count[2] = r.dw1[`CDS_CNT_B_MSB:`CDS_CNT_B_LSB];

   // sync stops on the first head word whose status matches
   assign match = (r.st == cds_pkg::cds_st_sync) & fifo_valid_i[0] &
                  (fifo_status_i == r.dw0[`CDS_SYNC_CODE_MSB:`CDS_SYNC_CODE_LSB]);
   // disable and line abort stop every lane
   assign eng_abort = {3{(r.st == cds_pkg::cds_st_idle) |
                         ((r.st == cds_pkg::cds_st_exec) & r.kill)}} | {2'b00, match};
   // luma end of line before its count is done
   assign eol_early = (r.st == cds_pkg::cds_st_exec) & eng_eol[0] & ~eng_done[0];

   // ****************************************************************
   // discard engines
   // ****************************************************************
   for (genvar g = 0; g < 3; g++) begin : g_lane
      assign dif[g].start = eng_start[g];
      assign dif[g].word_mode = eng_word[g];
      assign dif[g].abort = eng_abort[g];
      assign dif[g].count = eng_count[g];
      assign dif[g].fifo_valid = fifo_valid_i[g];
      assign dif[g].fifo_eol = fifo_eol_i[g];
      assign eng_done[g] = dif[g].done;
      assign eng_eol[g] = dif[g].eol_hit;
      assign fifo_pop_o[g] = dif[g].fifo_pop;

      cds_byte_discard u_eng (
         .core_clk_i(core_clk_i),
         .rst_i(rst_i),
         .bus(dif[g].eng)
      );
   end

   // ****************************************************************
   // apb slave, zero wait states
   // ****************************************************************
   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign apb_setup = psel_i & ~penable_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_ok(paddr_i);
   assign prdata_o = r.prdata;

   // ****************************************************************
   // outputs from state
   // ****************************************************************
   assign fetch_req_o = (r.st == cds_pkg::cds_st_fetch);
   assign fetch_addr_o = r.pc;
   assign program_status_flags_o = r.flags;
   assign irq_o = |(r.int_stat & r.int_mask);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      n = r;
      ev = 4'h0;
      clr = 4'h0;

      // register writes
      if (apb_wr) begin
         case (paddr_i)
            `CDS_REG_CTRL: n.en = pwdata_i[0];
            `CDS_REG_START_PC: n.start_pc = {pwdata_i[31:2], 2'b00};
            `CDS_REG_INT_STAT: clr = pwdata_i[3:0];
            `CDS_REG_INT_MASK: n.int_mask = pwdata_i[3:0];
            default: n.en = r.en;
         endcase
      end

      // read data captured in the setup phase
      if (apb_setup) begin
         case (paddr_i)
            `CDS_REG_CTRL: n.prdata = {31'h00000000, r.en};
            `CDS_REG_START_PC: n.prdata = r.start_pc;
            `CDS_REG_PC: n.prdata = r.pc;
            `CDS_REG_FLAGS: n.prdata = {23'h000000, r.st == cds_pkg::cds_st_halt,
                                        4'h0, r.flags};
            `CDS_REG_INT_STAT: n.prdata = {28'h0000000, r.int_stat};
            `CDS_REG_INT_MASK: n.prdata = {28'h0000000, r.int_mask};
            default: n.prdata = 32'h00000000;
         endcase
      end

      // sequencer
      case (r.st)
         // wait for the program to be enabled
         cds_pkg::cds_st_idle: begin
            if (r.en) begin
               n.pc = r.start_pc;
               n.st = cds_pkg::cds_st_fetch;
            end
         end
         // read one or two words at the program counter
         cds_pkg::cds_st_fetch: begin
            if (fetch_valid_i) begin
               n.pc = r.pc + 32'h00000004;
               if (!r.widx) begin
                  n.dw0 = fetch_data_i;
                  if (op_two_words(fetch_data_i[`CDS_OP_MSB:`CDS_OP_LSB])) begin
                     n.widx = 1'b1;
                  end else begin
                     n.st = cds_pkg::cds_st_decode;
                  end
               end else begin
                  n.dw1 = fetch_data_i;
                  n.widx = 1'b0;
                  n.st = cds_pkg::cds_st_decode;
               end
            end
         end
         // dispatch the held instruction
         cds_pkg::cds_st_decode: begin
            if (bad_instr) begin
               ev[`CDS_INT_ERROR] = 1'b1;
               n.st = cds_pkg::cds_st_halt;
            end else if (skip_it) begin
               // aborted discard; the one closing the line ends the abort
               if (r.dw0[`CDS_LINE_LAST_BIT]) begin
                  n.skip_line = 1'b0;
               end
               n.st = cds_pkg::cds_st_fetch;
            end else begin
               case (op)
                  `CDS_OP_PACKED_DISCARD: begin
                     n.skip_line = 1'b0;
                     n.done_mask = 3'h6 | eng_done;
                     n.st = cds_pkg::cds_st_exec;
                  end
                  `CDS_OP_PLANAR_DISCARD: begin
                     n.skip_line = 1'b0;
                     n.done_mask = eng_done;
                     n.st = cds_pkg::cds_st_exec;
                  end
                  `CDS_OP_BRANCH: begin
                     // taken always; low address bits forced to a word
                     n.pc = {r.dw1[31:2], 2'b00};
                     n.st = cds_pkg::cds_st_done;
                  end
                  `CDS_OP_SYNC: n.st = cds_pkg::cds_st_sync;
                  default: n.st = cds_pkg::cds_st_halt;
               endcase
            end
         end
         // discards running on one or three lanes
         cds_pkg::cds_st_exec: begin
            n.done_mask = r.done_mask | eng_done;
            if (r.kill) begin
               // abandon the instruction; skip to the line's last one
               ev[`CDS_INT_LINE_ABORT] = 1'b1;
               n.skip_line = ~r.dw0[`CDS_LINE_LAST_BIT];
               n.kill = 1'b0;
               n.st = cds_pkg::cds_st_fetch;
            end else if (eol_early) begin
               n.kill = 1'b1;
            end else if ((r.done_mask | eng_done) == 3'h7) begin
               n.st = cds_pkg::cds_st_done;
            end
         end
         // drop words until the status matches
         cds_pkg::cds_st_sync: begin
            if (match) begin
               n.st = cds_pkg::cds_st_done;
            end else if (fifo_pop_o[0] & ~r.dw0[`CDS_OVERRIDE_BIT]) begin
               ev[`CDS_INT_SYNC_ERR] = 1'b1;
            end
         end
         // apply the status flags and the interrupt request
         cds_pkg::cds_st_done: begin
            n.flags = (r.flags & ~r.dw0[`CDS_FLAG_CLR_MSB:`CDS_FLAG_CLR_LSB]) |
                      r.dw0[`CDS_FLAG_SET_MSB:`CDS_FLAG_SET_LSB];
            ev[`CDS_INT_INSTR] = r.dw0[`CDS_IRQ_BIT];
            n.st = cds_pkg::cds_st_fetch;
         end
         // stopped until the program is disabled and enabled again
         cds_pkg::cds_st_halt: n.st = cds_pkg::cds_st_halt;
         default: n.st = cds_pkg::cds_st_idle;
      endcase

      // disabling the program resets the sequencer
      if (!r.en) begin
         n.st = cds_pkg::cds_st_idle;
         n.widx = 1'b0;
         n.skip_line = 1'b0;
         n.kill = 1'b0;
      end

      // sticky status: a new event wins over a clear
      n.int_stat = (r.int_stat & ~clr) | ev;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.st <= cds_pkg::cds_st_idle;
         r.flags <= `CDS_RST_FLAGS;
         r.int_mask <= `CDS_RST_INT_MASK;
      end else begin
         r <= n;
      end
   end

endmodule // cds_sequencer

`default_nettype wire

//--- testbench/cds_seq_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// sequencer port checks
// ****
module cds_seq_properties (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // apb
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // fetch and fifos
   input wire logic fetch_req_o,
   input wire logic [31:0] fetch_addr_o,
   input wire logic fetch_valid_i,
   input wire logic [31:0] fetch_data_i,
   input wire logic [2:0] fifo_valid_i,
   input wire logic [2:0] fifo_pop_o,
   // status
   input wire logic [3:0] program_status_flags_o,
   input wire logic irq_o
);
   logic second_q; // next taken word is a second word
   logic [3:0] op_q; // opcode of the first word
   logic [31:0] tgt_q; // last taken word
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take; fetch_req_o && fetch_valid_i; endsequence
   sequence s_acc; psel_i && penable_i; endsequence
   // word order of two-word instructions, restarted by reset or enable write
   always_ff @(posedge core_clk_i) begin
      if (rst_i || (psel_i && penable_i && pwrite_i && paddr_i == 8'h00)) begin
         second_q <= 1'b0;
      end else if (fetch_req_o && fetch_valid_i) begin
         second_q <= !second_q && (fetch_data_i[31:28] inside {4'hA, 4'h7, 4'h8});
      end
      if (fetch_req_o && fetch_valid_i && !second_q) op_q <= fetch_data_i[31:28];
      if (fetch_req_o && fetch_valid_i) tgt_q <= fetch_data_i;
   end
   AST_POP_VALID: assert property ((fifo_pop_o & ~fifo_valid_i) == 3'h0)
      else $error("pop without fifo word");
   AST_POP_NO_FETCH: assert property (|fifo_pop_o |-> !fetch_req_o)
      else $error("pop while fetching");
   AST_PC_STEP: assert property (
      s_take ##0 !(second_q && op_q == 4'h7) |=> fetch_addr_o == $past(fetch_addr_o) + 32'h4)
      else $error("program counter did not step");
   AST_JUMP_TARGET: assert property (
      s_take ##0 (second_q && op_q == 4'h7)
      |-> ##[1:8] fetch_req_o && fetch_addr_o == {tgt_q[31:2], 2'b00})
      else $error("branch target not fetched");
   AST_HALT_QUIET: assert property (
      s_take ##0 (!second_q && !(fetch_data_i[31:28] inside {4'h2, 4'hA, 4'h7, 4'h8}))
      |=> (!fetch_req_o && fifo_pop_o == 3'h0) [*8])
      else $error("activity after bad opcode");
   AST_FLAGS_STABLE: assert property (
      fetch_req_o && $past(fetch_req_o) |-> $stable(program_status_flags_o))
      else $error("flags moved during fetch");
   AST_PREADY: assert property (s_acc |-> pready_o)
      else $error("no ready in access");
   AST_SLVERR: assert property (
      s_acc |-> pslverr_o == (paddr_i > 8'h14 || paddr_i[1:0] != 2'h0))
      else $error("wrong slave error");
   AST_RESET_QUIET: assert property (disable iff (1'b0) rst_i |=> !fetch_req_o && !irq_o
      && fifo_pop_o == 3'h0
      && program_status_flags_o == 4'h0)
      else $error("outputs active after reset");
endmodule // cds_seq_properties

bind cds_sequencer cds_seq_properties u_props (.*);
`default_nettype wire

//--- testbench/cds_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// host program memory and pixel fifos
// ****
module cds_host_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // instruction fetch
   input wire logic fetch_req_i,
   input wire logic [31:0] fetch_addr_i,
   output logic fetch_valid_o,
   output logic [31:0] fetch_data_o,
   // pixel fifos
   input wire logic [2:0] fifo_pop_i,
   output logic [2:0] fifo_valid_o,
   output logic [2:0] fifo_eol_o,
   output logic [3:0] fifo_status_o
);
   logic [31:0] mem [0:31]; // program words, loaded by the bench
   int lat = 0; // fetch answer delay
   int eol_at = -1; // luma word that ends the line
   logic slow = 1'b0; // fifos present data every other cycle
   int cnt [3]; // words popped per lane
   int wt = 0; // cycles waited on this fetch
   logic ph = 1'b0; // phase of slow fifos
   assign fifo_status_o = cnt[0][3:0];
   assign fifo_eol_o = {2'b00, cnt[0] == eol_at};
   assign fifo_valid_o = {3{!slow || ph}};
   // one answer pulse per word, data scrambled between answers
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         fetch_valid_o <= 1'b0;
         wt <= 0;
         ph <= 1'b0;
         cnt <= '{0, 0, 0};
      end else begin
         ph <= !ph;
         for (int i = 0; i < 3; i++) if (fifo_pop_i[i] && fifo_valid_o[i]) cnt[i] <= cnt[i] + 1;
         if (fetch_req_i && !fetch_valid_o && wt >= lat) begin
            fetch_valid_o <= 1'b1;
            fetch_data_o <= mem[fetch_addr_i[6:2]];
            wt <= 0;
         end else begin
            fetch_valid_o <= 1'b0;
            fetch_data_o <= ~fetch_data_o;
            if (fetch_req_i) wt <= wt + 1;
         end
      end
   end
endmodule // cds_host_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cds_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
 $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] paddr_i = 8'h00;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, fetch_addr_o, fetch_data_i, q;
   logic pready_o, pslverr_o, fetch_req_o, fetch_valid_i, irq_o, e;
   logic [2:0] fifo_valid_i, fifo_eol_i, fifo_pop_o;
   logic [3:0] fifo_status_i, program_status_flags_o;
   int error_cnt = 0;
   int check_count = 0;
   always #20 core_clk_i = ~core_clk_i;
   cds_sequencer dut (.*);
   cds_host_model host (.core_clk_i(core_clk_i), .rst_i(rst_i), .fetch_req_i(fetch_req_o),
      .fetch_addr_i(fetch_addr_o), .fetch_valid_o(fetch_valid_i), .fetch_data_o(fetch_data_i),
      .fifo_pop_i(fifo_pop_o), .fifo_valid_o(fifo_valid_i), .fifo_eol_o(fifo_eol_i),
      .fifo_status_o(fifo_status_i));
   // ****
   // bus tasks
   // ****
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do @(posedge core_clk_i); while (pready_o !== 1'b1 && n++ < 20);
      `CHK(pready_o, 1'b1)
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      apb(1'b0, a, 32'h0);
      `CHK(q, want)
   endtask
   // reset, start at word 0, poll until halted
   task automatic go();
      int n = 0;
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      apb(1'b1, `CDS_REG_START_PC, 32'h0);
      apb(1'b1, `CDS_REG_CTRL, 32'h1);
      do apb(1'b0, `CDS_REG_FLAGS, 32'h0); while (q[`CDS_HALT_BIT] !== 1'b1 && n++ < 300);
      `CHK(q[`CDS_HALT_BIT], 1'b1)
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_regs();
      rd(`CDS_REG_INT_MASK, {28'h0, `CDS_RST_INT_MASK});
      apb(1'b1, `CDS_REG_FLAGS, 32'hF);
      rd(`CDS_REG_FLAGS, 32'h0);
      apb(1'b1, `CDS_REG_START_PC, 32'h33);
      rd(`CDS_REG_START_PC, 32'h30);
      rd(8'h20, 32'h0);
      `CHK(e, 1'b1)
      $display("end regs");
   endtask
   task automatic t_packed();
      host.mem[0] = 32'h2103_0006;
      host.mem[1] = 32'h2010_0002;
      host.mem[2] = 32'h0;
      go();
      `CHK(host.cnt[0], 2)
      `CHK(program_status_flags_o, 4'h2)
      `CHK(irq_o, 1'b0)
      apb(1'b1, `CDS_REG_INT_MASK, 32'h1);
      `CHK(irq_o, 1'b1)
      apb(1'b1, `CDS_REG_INT_STAT, 32'h1);
      `CHK(irq_o, 1'b0)
      rd(`CDS_REG_INT_STAT, 32'h2);
      $display("end packed");
   endtask
   task automatic t_planar();
      host.slow = 1'b1;
      host.mem[0] = 32'hA000_0005;
      host.mem[1] = 32'h0003_0009;
      host.mem[2] = 32'hA000_0003;
      host.mem[3] = 32'h0001_0007;
      host.mem[4] = 32'h0;
      go();
      `CHK(host.cnt[0], 2)
      `CHK(host.cnt[1], 4)
      `CHK(host.cnt[2], 1)
      host.slow = 1'b0;
      $display("end planar");
   endtask
   task automatic t_jump();
      host.lat = 3;
      host.mem[0] = 32'h7004_0000;
      host.mem[1] = 32'h0000_0040;
      host.mem[2] = 32'h2000_0008;
      host.mem[16] = 32'h2000_0004;
      host.mem[17] = 32'h0;
      go();
      `CHK(host.cnt[0], 1)
      `CHK(program_status_flags_o, 4'h4)
      host.lat = 0;
      $display("end jump");
   endtask
   task automatic t_sync();
      for (int i = 0; i < 2; i++) begin
         host.mem[0] = (i == 0) ? 32'h8000_0003 : 32'h8000_8003;
         host.mem[1] = 32'h0;
         host.mem[2] = 32'h2000_0004;
         host.mem[3] = 32'h0;
         go();
         `CHK(host.cnt[0], 4)
         rd(`CDS_REG_INT_STAT, (i == 0) ? 32'h6 : 32'h2);
      end
      $display("end sync");
   endtask
   task automatic t_bad();
      logic [31:0] bad [5] = '{32'h0, 32'h1000_0000, 32'h5000_0000, 32'hF000_0000, 32'h8000_0000};
      for (int i = 0; i < 5; i++) begin
         host.mem[0] = bad[i];
         host.mem[1] = 32'h0;
         host.mem[2] = 32'h2000_0004;
         go();
         `CHK(host.cnt[0], 0)
         rd(`CDS_REG_INT_STAT, 32'h2);
      end
      $display("end bad");
   endtask
   task automatic t_eol();
      host.eol_at = 1;
      host.mem[0] = 32'h2000_0014;
      host.mem[1] = 32'h2000_0004;
      host.mem[2] = 32'h2400_0004;
      host.mem[3] = 32'h2800_0004;
      host.mem[4] = 32'h0;
      go();
      `CHK(host.cnt[0], 3)
      rd(`CDS_REG_INT_STAT, 32'hA);
      host.eol_at = -1;
      $display("end eol");
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_packed();
      t_planar();
      t_jump();
      t_sync();
      t_bad();
      t_eol();
      final_report();
   end
   // watchdog
   initial begin
      repeat (40000) @(posedge core_clk_i);
      error_cnt++;
      final_report();
   end
endmodule // tb
`default_nettype wire
